//--- verilog/amd_pkg.sv
`default_nettype none
package amd_pkg;
	// ****************************************
	// Prefix, opcode and mask level codes
	// ****************************************
	localparam logic [7:0] PRE_Y = 8'h90;
	localparam logic [7:0] PRE_IY = 8'h91;
	localparam logic [7:0] PRE_IND = 8'h92;
	localparam logic [7:0] OP_NOP = 8'h9D;
	localparam logic [7:0] OP_HALT = 8'h8E;
	localparam logic [7:0] OP_WAIT = 8'h8F;
	localparam logic [7:0] OP_SET_MASK = 8'h9B;
	localparam logic [7:0] OP_CLR_MASK = 8'h9A;
	localparam logic [1:0] MASK_LVL_SET = 2'h3;
	localparam logic [1:0] MASK_LVL_CLR = 2'h0;

	// ****************************************
	// Addressing modes
	// ****************************************
	typedef enum logic [3:0] {
		AM_INH = 4'h0,
		AM_IMM = 4'h1,
		AM_DIR_S = 4'h2,
		AM_DIR_L = 4'h3,
		AM_IDX_0 = 4'h4,
		AM_IDX_S = 4'h5,
		AM_IDX_L = 4'h6,
		AM_IND_S = 4'h7,
		AM_IND_L = 4'h8,
		AM_IND_IDX_S = 4'h9,
		AM_IND_IDX_L = 4'hA,
		AM_REL = 4'hB,
		AM_BAD = 4'hF
	} amd_mode_e;

	// Opcode high nibble columns
	localparam logic [3:0] COL_IMM = 4'hA;
	localparam logic [3:0] COL_DIR_S = 4'hB;
	localparam logic [3:0] COL_DIR_L = 4'hC;
	localparam logic [3:0] COL_IDX_L = 4'hD;
	localparam logic [3:0] COL_IDX_S = 4'hE;
	localparam logic [3:0] COL_IDX_0 = 4'hF;
	localparam logic [3:0] COL_RMW_D = 4'h3;
	localparam logic [3:0] COL_RMW_X = 4'h7;
	localparam logic [3:0] COL_RMW_XS = 4'h6;
	localparam logic [3:0] COL_BIT = 4'h1;
	localparam logic [3:0] COL_BTJ = 4'h0;
	localparam logic [3:0] COL_REL = 4'h2;
	localparam logic [3:0] COL_INH_A = 4'h4;
	localparam logic [3:0] COL_INH_X = 4'h5;
	localparam logic [3:0] COL_MISC = 4'h8;
	localparam logic [3:0] COL_MISC2 = 4'h9;

	localparam logic [7:0] SHORT_PAGE = 8'h00;
	localparam int N_INSTR = 63;
	localparam int N_GROUPS = 13;
endpackage
`default_nettype wire

//--- verilog/amd_mode_lut.sv
`default_nettype none
module amd_mode_lut (
	input wire logic [7:0] opcode,
	input wire logic [1:0] prefix,
	output amd_pkg::amd_mode_e mode,
	output logic [1:0] extra_bytes,
	output logic use_y,
	output logic valid
);
	// prefix: 0 none, 1 y-substitution, 2 indirect-y, 3 indirect
	wire [3:0] hi = opcode[7:4];
	amd_pkg::amd_mode_e base;
	always_comb begin
		case (hi)
			amd_pkg::COL_IMM: base = amd_pkg::AM_IMM;
			amd_pkg::COL_DIR_S, amd_pkg::COL_RMW_D, amd_pkg::COL_BIT, amd_pkg::COL_BTJ:
				base = amd_pkg::AM_DIR_S;
			amd_pkg::COL_DIR_L: base = amd_pkg::AM_DIR_L;
			amd_pkg::COL_IDX_L: base = amd_pkg::AM_IDX_L;
			amd_pkg::COL_IDX_S, amd_pkg::COL_RMW_XS: base = amd_pkg::AM_IDX_S;
			amd_pkg::COL_IDX_0, amd_pkg::COL_RMW_X: base = amd_pkg::AM_IDX_0;
			amd_pkg::COL_REL: base = amd_pkg::AM_REL;
			default: base = amd_pkg::AM_INH;
		endcase
	end
	wire is_dir = (base == amd_pkg::AM_DIR_S) || (base == amd_pkg::AM_DIR_L);
	wire is_idx = (base == amd_pkg::AM_IDX_S) || (base == amd_pkg::AM_IDX_L);
	wire rel_ok = (hi == amd_pkg::COL_REL);
	always_comb begin
		mode = base;
		use_y = 1'b0;
		valid = 1'b1;
		case (prefix)
			2'd1: begin
				// Y replaces X; relative has no X form
				use_y = 1'b1;
				valid = !rel_ok;
			end
			2'd3: begin
				if (is_dir || rel_ok)
					mode = (base == amd_pkg::AM_DIR_L) ? amd_pkg::AM_IND_L : amd_pkg::AM_IND_S;
				else if (is_idx)
					mode = (base == amd_pkg::AM_IDX_L) ? amd_pkg::AM_IND_IDX_L
						: amd_pkg::AM_IND_IDX_S;
				else
					valid = 1'b0;
			end
			2'd2: begin
				// only the indirect Y indexed forms
				use_y = 1'b1;
				if (is_idx)
					mode = (base == amd_pkg::AM_IDX_L) ? amd_pkg::AM_IND_IDX_L
						: amd_pkg::AM_IND_IDX_S;
				else
					valid = 1'b0;
			end
			default: ;
		endcase
		if (!valid)
			mode = amd_pkg::AM_BAD;
	end
	always_comb begin
		case (mode)
			amd_pkg::AM_INH, amd_pkg::AM_IDX_0, amd_pkg::AM_BAD: extra_bytes = 2'd0;
			amd_pkg::AM_DIR_L, amd_pkg::AM_IDX_L: extra_bytes = 2'd2;
			default: extra_bytes = 2'd1;
		endcase
	end
endmodule
`default_nettype wire

//--- verilog/amd_ea_calc.sv
`default_nettype none
module amd_ea_calc (
	input wire amd_pkg::amd_mode_e mode,
	input wire logic [7:0] ext_hi,
	input wire logic [7:0] ext_lo,
	input wire logic [7:0] index,
	input wire logic [15:0] pointer,
	output logic [15:0] ea
);
	wire [15:0] word_off = {ext_hi, ext_lo};
	always_comb begin
		case (mode)
			amd_pkg::AM_DIR_S: ea = {amd_pkg::SHORT_PAGE, ext_lo};
			amd_pkg::AM_DIR_L: ea = word_off;
			amd_pkg::AM_IDX_0: ea = {amd_pkg::SHORT_PAGE, index};
			amd_pkg::AM_IDX_S: ea = {8'h00, ext_lo} + {8'h00, index};
			amd_pkg::AM_IDX_L: ea = word_off + {8'h00, index};
			amd_pkg::AM_IND_S: ea = {amd_pkg::SHORT_PAGE, pointer[7:0]};
			amd_pkg::AM_IND_L: ea = pointer;
			amd_pkg::AM_IND_IDX_S: ea = {8'h00, pointer[7:0]} + {8'h00, index};
			amd_pkg::AM_IND_IDX_L: ea = pointer + {8'h00, index};
			default: ea = 16'h0000;
		endcase
	end
endmodule
`default_nettype wire

//--- verilog/amd_decoder.sv
`default_nettype none
module amd_decoder (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	input wire logic [7:0] x_index,
	input wire logic [7:0] y_index,
	output logic mem_rd,
	output logic [15:0] mem_addr,
	input wire logic mem_valid,
	input wire logic [7:0] mem_data,
	output logic dec_valid,
	input wire logic dec_ready,
	output logic [7:0] dec_opcode,
	output logic [3:0] dec_mode,
	output logic [2:0] dec_length,
	output logic [7:0] dec_operand,
	output logic [15:0] dec_ea,
	output logic dec_use_y,
	output logic dec_undef,
	input wire logic irq,
	output logic [1:0] int_mask_level,
	output logic osc_stop,
	output logic wait_low_power
);
	// ****************************************
	// State machine
	// ****************************************
	typedef enum logic [6:0] {
		ST_OP = 7'b000_0001,
		ST_EXT1 = 7'b000_0010,
		ST_EXT2 = 7'b000_0100,
		ST_PTR_HI = 7'b000_1000,
		ST_PTR_LO = 7'b001_0000,
		ST_DONE = 7'b010_0000,
		ST_PREOP = 7'b100_0000
	} amd_state_e;
	amd_state_e state_q, state_d;
	logic [7:0] opcode_q, ext1_q, ext2_q, ptr_hi_q, ptr_lo_q;
	logic [1:0] prefix_q;
	logic [2:0] length_q;
	logic [1:0] mask_q;
	logic halt_q, wait_q;

	amd_pkg::amd_mode_e lut_mode;
	logic [1:0] lut_extra;
	logic lut_use_y, lut_valid;
	wire [7:0] lut_op = (state_q == ST_OP || state_q == ST_PREOP) ? byte_data : opcode_q;
	wire [1:0] lut_pre = (state_q == ST_OP) ? 2'd0 : prefix_q;
	amd_mode_lut u_lut (
		.opcode(lut_op),
		.prefix(lut_pre),
		.mode(lut_mode),
		.extra_bytes(lut_extra),
		.use_y(lut_use_y),
		.valid(lut_valid)
	);

	// ****************************************
	// Effective address
	// ****************************************
	logic [15:0] ea;
	wire [7:0] idx = lut_use_y ? y_index : x_index;
	wire is_ind = (lut_mode == amd_pkg::AM_IND_S) || (lut_mode == amd_pkg::AM_IND_L) ||
		(lut_mode == amd_pkg::AM_IND_IDX_S) || (lut_mode == amd_pkg::AM_IND_IDX_L);
	wire word_ptr = (lut_mode == amd_pkg::AM_IND_L) || (lut_mode == amd_pkg::AM_IND_IDX_L);
	// Last byte lands on the same edge as the result, so bypass its register
	wire [7:0] ext1_now = (state_q == ST_EXT1) ? byte_data : ext1_q;
	wire [7:0] ext2_now = (state_q == ST_EXT2) ? byte_data : ext2_q;
	wire [7:0] ptr_lo_now = (state_q == ST_PTR_LO) ? mem_data : ptr_lo_q;
	wire [7:0] hi_b = (lut_extra == 2'd2) ? ext1_now : 8'h00;
	wire [7:0] lo_b = (lut_extra == 2'd2) ? ext2_now : ext1_now;
	wire [15:0] ptr = word_ptr ? {ptr_hi_q, ptr_lo_now} : {8'h00, ptr_lo_now};
	amd_ea_calc u_ea (
		.mode(lut_mode),
		.ext_hi(hi_b),
		.ext_lo(lo_b),
		.index(idx),
		.pointer(ptr),
		.ea(ea)
	);

	// only three codes count as prefixes
	wire is_prefix = (byte_data == amd_pkg::PRE_Y) || (byte_data == amd_pkg::PRE_IY) ||
		(byte_data == amd_pkg::PRE_IND);
	wire [1:0] pre_code = (byte_data == amd_pkg::PRE_Y) ? 2'd1 :
		(byte_data == amd_pkg::PRE_IY) ? 2'd2 : 2'd3;
	wire take = byte_valid && byte_ready;
	wire [2:0] len_next = (state_q == ST_OP) ? 3'd1 : 3'(length_q + 3'd1);
	wire ptr_addr_ok = (lut_extra == 2'd1) ? 1'b1 : 1'b0;
	// Stream paused while pointer read or result waits
	assign byte_ready = (state_q == ST_OP) || (state_q == ST_PREOP) ||
		(state_q == ST_EXT1) || (state_q == ST_EXT2);
	assign mem_rd = (state_q == ST_PTR_HI) || (state_q == ST_PTR_LO);
	// word pointer high byte first, at pointer address then next
	assign mem_addr = (state_q == ST_PTR_HI) || !word_ptr ? {8'h00, ext1_q} :
		{8'h00, 8'(ext1_q + 8'h01)};
	assign dec_valid = (state_q == ST_DONE);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OP, ST_PREOP:
				if (take) begin
					if (state_q == ST_OP && is_prefix)
						state_d = ST_PREOP;
					else if (lut_extra == 2'd0)
						state_d = ST_DONE;
					else
						state_d = ST_EXT1;
				end
			ST_EXT1:
				if (take) begin
					if (lut_extra == 2'd2)
						state_d = ST_EXT2;
					else if (is_ind && ptr_addr_ok)
						state_d = word_ptr ? ST_PTR_HI : ST_PTR_LO;
					else
						state_d = ST_DONE;
				end
			ST_EXT2:
				if (take)
					state_d = ST_DONE;
			ST_PTR_HI:
				if (mem_valid)
					state_d = ST_PTR_LO;
			ST_PTR_LO:
				if (mem_valid)
					state_d = ST_DONE;
			ST_DONE:
				if (dec_ready)
					state_d = ST_OP;
			default: state_d = ST_OP;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_OP;
			prefix_q <= 2'd0;
			opcode_q <= 8'h00;
			ext1_q <= 8'h00;
			ext2_q <= 8'h00;
			ptr_hi_q <= 8'h00;
			ptr_lo_q <= 8'h00;
			length_q <= 3'd0;
		end else begin
			state_q <= state_d;
			if (take) begin
				length_q <= len_next;
				if (state_q == ST_OP && is_prefix)
					prefix_q <= pre_code;
				else if (state_q == ST_OP)
					prefix_q <= 2'd0;
				if (state_q == ST_OP || state_q == ST_PREOP)
					opcode_q <= byte_data;
				if (state_q == ST_EXT1)
					ext1_q <= byte_data;
				if (state_q == ST_EXT2)
					ext2_q <= byte_data;
			end
			if (mem_valid && state_q == ST_PTR_HI)
				ptr_hi_q <= mem_data;
			if (mem_valid && state_q == ST_PTR_LO)
				ptr_lo_q <= mem_data;
			if (state_q == ST_OP)
				ptr_hi_q <= 8'h00;
		end
	end

	// ****************************************
	// Result register
	// ****************************************
	wire load_res = (state_d == ST_DONE) && (state_q != ST_DONE);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dec_opcode <= 8'h00;
			dec_mode <= 4'h0;
			dec_length <= 3'd0;
			dec_operand <= 8'h00;
			dec_ea <= 16'h0000;
			dec_use_y <= 1'b0;
			dec_undef <= 1'b0;
		end else if (load_res) begin
			dec_opcode <= lut_op;
			dec_mode <= lut_mode;
			dec_length <= take ? len_next : length_q;
			dec_operand <= (take && state_q == ST_EXT1) ? byte_data : ext1_q;
			dec_ea <= ea;
			dec_use_y <= lut_use_y;
			dec_undef <= !lut_valid;
		end
	end

	// ****************************************
	// Mask and power control
	// ****************************************
	wire commit = dec_valid && dec_ready && !dec_undef;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= amd_pkg::MASK_LVL_SET;
			halt_q <= 1'b0;
			wait_q <= 1'b0;
		end else begin
			if (commit && dec_opcode == amd_pkg::OP_SET_MASK)
				mask_q <= amd_pkg::MASK_LVL_SET;
			else if (commit && dec_opcode == amd_pkg::OP_CLR_MASK)
				mask_q <= amd_pkg::MASK_LVL_CLR;
			// Only reset leaves halt, since the clock is gone
			if (commit && dec_opcode == amd_pkg::OP_HALT)
				halt_q <= 1'b1;
			if (commit && dec_opcode == amd_pkg::OP_WAIT)
				wait_q <= 1'b1;
			else if (irq)
				wait_q <= 1'b0;
		end
	end
	assign int_mask_level = mask_q;
	assign osc_stop = halt_q;
	assign wait_low_power = wait_q;
	// group recognition lies in the column table of the mode lookup
endmodule
`default_nettype wire

//--- test/amd_chk.sv
`default_nettype none
module amd_chk (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic mem_valid,
	input wire logic dec_valid,
	input wire logic dec_ready,
	input wire logic [7:0] dec_opcode,
	input wire logic [3:0] dec_mode,
	input wire logic [2:0] dec_length,
	input wire logic [15:0] dec_ea,
	input wire logic dec_use_y,
	input wire logic dec_undef,
	input wire logic [1:0] int_mask_level,
	input wire logic osc_stop
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Decode and pointer checks
	// ****************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [2:0] core_len;
	// Prefixes 90 and 91 set use_y and add one byte, so strip it before length checks
	assign core_len = dec_length - {2'h0, dec_use_y};
	sequence done_s(logic [7:0] op);
		dec_valid && dec_ready && !dec_undef && dec_opcode == op;
	endsequence
	sequence ptr_wait_s;
		mem_rd && !mem_valid;
	endsequence
	inh_length_a: assert property (dec_valid && dec_mode == amd_pkg::AM_INH |->
		core_len == 3'h1) else $error("inherent length wrong");
	imm_length_a: assert property (dec_valid && dec_mode == amd_pkg::AM_IMM |->
		core_len == 3'h2) else $error("immediate length wrong");
	short_dir_a: assert property (dec_valid && dec_mode == amd_pkg::AM_DIR_S |->
		dec_ea[15:8] == 8'h00 && core_len == 3'h2) else $error("short direct wrong");
	no_offset_a: assert property (dec_valid && dec_mode == amd_pkg::AM_IDX_0 |->
		dec_ea[15:8] == 8'h00 && core_len == 3'h1) else $error("no offset index wrong");
	short_idx_a: assert property (dec_valid && dec_mode == amd_pkg::AM_IDX_S |->
		dec_ea <= 16'h01FE) else $error("short index range wrong");
	short_ind_a: assert property (dec_valid && dec_mode == amd_pkg::AM_IND_S |->
		dec_ea[15:8] == 8'h00 && dec_length == 3'h3) else $error("short indirect wrong");
	length_range_a: assert property (dec_valid |-> dec_length inside {[3'h1:3'h4]})
		else $error("length out of range");
	undef_mode_a: assert property (dec_valid && dec_undef |->
		dec_mode == amd_pkg::AM_BAD) else $error("undefined not flagged");
	mask_set_a: assert property (done_s(amd_pkg::OP_SET_MASK) |=>
		int_mask_level == amd_pkg::MASK_LVL_SET) else $error("mask not set");
	mask_clr_a: assert property (done_s(amd_pkg::OP_CLR_MASK) |=>
		int_mask_level == amd_pkg::MASK_LVL_CLR) else $error("mask not cleared");
	halt_stop_a: assert property (done_s(amd_pkg::OP_HALT) |=> osc_stop)
		else $error("halt did not stop");
	ptr_hold_a: assert property (ptr_wait_s |=> mem_rd && $stable(mem_addr))
		else $error("pointer request dropped");
endmodule
bind amd_decoder amd_chk i_chk (.clk_sys(clk_sys), .arst_n(arst_n), .mem_rd(mem_rd),
	.mem_addr(mem_addr), .mem_valid(mem_valid), .dec_valid(dec_valid),
	.dec_ready(dec_ready), .dec_opcode(dec_opcode), .dec_mode(dec_mode),
	.dec_length(dec_length), .dec_ea(dec_ea), .dec_use_y(dec_use_y),
	.dec_undef(dec_undef), .int_mask_level(int_mask_level), .osc_stop(osc_stop));
`default_nettype wire

//--- test/amd_mem_model.sv
`default_nettype none
module amd_mem_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic [1:0] lag,
	output logic mem_valid,
	output logic [7:0] mem_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_q;
	// Data toggles outside the valid cycle so a sample one cycle late does not match
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mem_valid <= 1'b0;
			mem_data <= 8'h00;
			cnt_q <= 2'h0;
		end else if (mem_rd && !mem_valid && cnt_q >= lag) begin
			mem_valid <= 1'b1;
			mem_data <= mem_addr[7:0] ^ 8'hC3;
			cnt_q <= 2'h0;
		end else begin
			mem_valid <= 1'b0;
			mem_data <= ~mem_data;
			cnt_q <= (mem_rd && !mem_valid) ? cnt_q + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

//--- test/cpu_addressing_mode_decoder_tb.sv
`default_nettype none
module cpu_addressing_mode_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, arst_n, byte_valid, byte_ready, mem_rd, mem_valid, dec_valid, dec_ready;
	logic irq, dec_use_y, dec_undef, osc_stop, wait_low_power;
	logic [7:0] byte_data, x_index, y_index, mem_data, dec_opcode, dec_operand, pre, rv;
	logic [15:0] mem_addr, dec_ea;
	logic [3:0] dec_mode, col;
	logic [2:0] dec_length;
	logic [1:0] int_mask_level, lag;
	int miscompares, total_checks;
	amd_decoder i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .byte_valid(byte_valid),
		.byte_data(byte_data), .byte_ready(byte_ready), .x_index(x_index),
		.y_index(y_index), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_valid(mem_valid),
		.mem_data(mem_data), .dec_valid(dec_valid), .dec_ready(dec_ready),
		.dec_opcode(dec_opcode), .dec_mode(dec_mode), .dec_length(dec_length),
		.dec_operand(dec_operand), .dec_ea(dec_ea), .dec_use_y(dec_use_y),
		.dec_undef(dec_undef), .irq(irq), .int_mask_level(int_mask_level),
		.osc_stop(osc_stop), .wait_low_power(wait_low_power));
	amd_mem_model i_mem (.clk_sys(clk_sys), .arst_n(arst_n), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .lag(lag), .mem_valid(mem_valid), .mem_data(mem_data));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Consumer stalls about one cycle in four
	always @(posedge clk_sys) dec_ready <= ($urandom % 4) != 0;
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [7:0] ptr(input logic [7:0] a);
		return a ^ 8'hC3;
	endfunction
	task automatic put(input logic [7:0] b);
		byte_valid <= 1'b1;
		byte_data <= b;
		do @(posedge clk_sys); while (byte_ready !== 1'b1);
	endtask
	task automatic run(input logic [7:0] pr, op, b1, b2, xv);
		logic [3:0] m;
		logic [2:0] n;
		logic [15:0] ea, w;
		logic [7:0] ix;
		logic y, ind, u;
		int k;
		y = pr == 8'h90 || pr == 8'h91;
		ind = pr == 8'h92 || pr == 8'h91;
		ix = y ? ~xv : xv;
		w = {ptr(b1), ptr(b1 + 8'h01)};
		n = 3'h1;
		ea = 16'h0000;
		x_index <= xv;
		y_index <= ~xv;
		lag <= 2'($urandom);
		case (op[7:4])
			4'hA: m = amd_pkg::AM_IMM;
			4'hB: begin
				m = ind ? amd_pkg::AM_IND_S : amd_pkg::AM_DIR_S;
				ea = {8'h00, ind ? ptr(b1) : b1};
			end
			4'hC: begin
				m = ind ? amd_pkg::AM_IND_L : amd_pkg::AM_DIR_L;
				ea = ind ? w : {b1, b2};
				n = ind ? 3'h1 : 3'h2;
			end
			4'hD: begin
				m = ind ? amd_pkg::AM_IND_IDX_L : amd_pkg::AM_IDX_L;
				ea = (ind ? w : {b1, b2}) + {8'h00, ix};
				n = ind ? 3'h1 : 3'h2;
			end
			4'hE: begin
				m = ind ? amd_pkg::AM_IND_IDX_S : amd_pkg::AM_IDX_S;
				ea = {8'h00, ind ? ptr(b1) : b1} + {8'h00, ix};
			end
			4'hF: begin
				m = amd_pkg::AM_IDX_0;
				ea = {8'h00, ix};
				n = 3'h0;
			end
			default: begin
				m = amd_pkg::AM_INH;
				n = 3'h0;
			end
		endcase
		u = pr == 8'h92 && m == amd_pkg::AM_INH;
		if (u) m = amd_pkg::AM_BAD;
		repeat ($urandom % 2) @(posedge clk_sys);
		if (pr != 8'h00) put(pr);
		put(op);
		if (n > 3'h0) put(b1);
		if (n > 3'h1) put(b2);
		byte_valid <= 1'b0;
		k = 0;
		do @(posedge clk_sys); while (!(dec_valid === 1'b1 && dec_ready === 1'b1) && ++k < 60);
		chk(dec_mode, m, "mode");
		chk(dec_opcode, op, "opcode");
		chk(dec_undef, u, "undef");
		if (!u) chk(dec_length, n + 3'h1 + (pr != 8'h00), "length");
		if (!u) chk(dec_use_y, y, "use y");
		if (m == amd_pkg::AM_IMM) chk(dec_operand, b1, "operand");
		else if (n > 3'h0 || m == amd_pkg::AM_IDX_0) chk(dec_ea, ea, "ea");
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{arst_n, byte_valid, byte_data, x_index, y_index, irq, lag} = '0;
		rv = 8'($urandom(71));
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		chk(int_mask_level, amd_pkg::MASK_LVL_SET, "mask reset");
		run(8'h00, 8'hE1, 8'hFF, 8'h00, 8'hFF);
		run(8'h00, 8'hD6, 8'hFF, 8'hFF, 8'h02);
		run(8'h00, 8'hC6, 8'h12, 8'h34, 8'h00);
		run(8'h92, 8'hB6, 8'h10, 8'h00, 8'h00);
		run(8'h92, 8'hC6, 8'hFF, 8'h00, 8'h00);
		run(8'h92, 8'hE6, 8'hF0, 8'h00, 8'h40);
		run(8'h91, 8'hD6, 8'hFE, 8'h00, 8'h33);
		run(8'h90, 8'hF6, 8'h00, 8'h00, 8'hA5);
		run(8'h92, amd_pkg::OP_NOP, 8'h00, 8'h00, 8'h00);
		run(8'h00, amd_pkg::OP_CLR_MASK, 8'h00, 8'h00, 8'h00);
		@(posedge clk_sys);
		chk(int_mask_level, amd_pkg::MASK_LVL_CLR, "mask clear");
		run(8'h00, amd_pkg::OP_SET_MASK, 8'h00, 8'h00, 8'h00);
		@(posedge clk_sys);
		chk(int_mask_level, amd_pkg::MASK_LVL_SET, "mask set");
		repeat (300) begin
			col = 4'hA + 4'($urandom % 6);
			rv = 8'($urandom % 4);
			pre = rv == 8'h0 ? 8'h00 : (col == 4'hD || col == 4'hE) ? 8'h8F + rv :
				(col == 4'hA || col == 4'hF) ? 8'h90 : 8'h92;
			run(pre, {col, 4'($urandom % 7)}, 8'($urandom), 8'($urandom), 8'($urandom));
		end
		run(8'h00, amd_pkg::OP_WAIT, 8'h00, 8'h00, 8'h00);
		@(posedge clk_sys);
		chk(wait_low_power, 1'b1, "wait entry");
		irq <= 1'b1;
		repeat (2) @(posedge clk_sys);
		irq <= 1'b0;
		chk(wait_low_power, 1'b0, "wait exit");
		run(8'h00, amd_pkg::OP_HALT, 8'h00, 8'h00, 8'h00);
		@(posedge clk_sys);
		chk(osc_stop, 1'b1, "halt");
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		complete_run();
	end
endmodule
`default_nettype wire
